//--- pkg/pssb_pkg.sv
package pssb_pkg;

   // Bus geometry
   localparam int PSSB_ADDR_W = 8;
   localparam int PSSB_DATA_W = 32;
   localparam int PSSB_REG_W = 16;

   // Register indices; byte address is four times the index
   localparam logic [PSSB_ADDR_W-1:0] PSSB_IDX_CTRL_ONE = 8'h09;
   localparam logic [PSSB_ADDR_W-1:0] PSSB_IDX_CTRL_TWO = 8'h0A;
   localparam logic [PSSB_ADDR_W-1:0] PSSB_ADDR_CTRL_ONE = 8'h24;
   localparam logic [PSSB_ADDR_W-1:0] PSSB_ADDR_CTRL_TWO = 8'h28;

   // Field positions in strap_control_one
   localparam int PSSB_ONE_CFG_DONE = 15;
   localparam int PSSB_ONE_FAST_MDIX = 6;
   localparam int PSSB_ONE_ROBUST_MDIX = 5;

   // Field positions in strap_control_two
   localparam int PSSB_TWO_FAST_PD = 6;
   localparam int PSSB_TWO_FD_EXT = 5;
   localparam int PSSB_TWO_LED_FD = 4;
   localparam int PSSB_TWO_ISOLATE = 3;
   localparam int PSSB_TWO_IDLE_ERR = 2;
   localparam int PSSB_TWO_ODD_DIS = 1;
   localparam int PSSB_TWO_RMII_CLK = 0;

   // Reset values and writable masks
   localparam logic [PSSB_REG_W-1:0] PSSB_ONE_RST = 16'h0000;
   localparam logic [PSSB_REG_W-1:0] PSSB_TWO_RST = 16'h0004;
   localparam logic [PSSB_REG_W-1:0] PSSB_ONE_WMASK = 16'hFFFF;
   localparam logic [PSSB_REG_W-1:0] PSSB_TWO_WMASK = 16'h3FFF;

   // AXI responses
   localparam logic [1:0] PSSB_RESP_OKAY = 2'h0;
   localparam logic [1:0] PSSB_RESP_SLVERR = 2'h2;

   // Register select codes
   localparam logic [1:0] PSSB_SEL_NONE = 2'h0;
   localparam logic [1:0] PSSB_SEL_ONE = 2'h1;
   localparam logic [1:0] PSSB_SEL_TWO = 2'h2;

   // Link state reported by the PCS and negotiation logic
   typedef struct packed {
      logic link_up;
      logic speed_100;
      logic partner_forced_100;
      logic local_an_or_forced_100;
      logic std_full_duplex;
   } pssb_link_t;

   // Latched strap configuration in effect
   typedef struct packed {
      logic fast_pd_linkup;
      logic forced_full_duplex_ext;
      logic link_indicator_fd_only;
      logic isolate_on_half_duplex;
      logic idle_symbol_error_detect;
      logic odd_nibble_disable;
      logic rmii_rx_on_rx_clk;
   } pssb_cfg_t;

   // Address decode shared by the bus slave and the register file
   function automatic logic [1:0] pssb_reg_sel(input logic [PSSB_ADDR_W-1:0] addr);
      logic [1:0] sel;
      sel = PSSB_SEL_NONE;
      if (addr == PSSB_ADDR_CTRL_ONE) begin
         sel = PSSB_SEL_ONE;
      end else if (addr == PSSB_ADDR_CTRL_TWO) begin
         sel = PSSB_SEL_TWO;
      end
      return sel;
   endfunction : pssb_reg_sel

endpackage : pssb_pkg

//--- verilog/pssb_axil.sv
`timescale 1ns/10ps
`default_nettype none
module pssb_axil (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   // Write address and data
   input wire logic [pssb_pkg::PSSB_ADDR_W-1:0] s_awaddr_i,
   input wire logic s_awvalid_i,
   output logic s_awready_o,
   input wire logic [pssb_pkg::PSSB_DATA_W-1:0] s_wdata_i,
   input wire logic [3:0] s_wstrb_i,
   input wire logic s_wvalid_i,
   output logic s_wready_o,
   // Write response
   output logic [1:0] s_bresp_o,
   output logic s_bvalid_o,
   input wire logic s_bready_i,
   // Read address and data
   input wire logic [pssb_pkg::PSSB_ADDR_W-1:0] s_araddr_i,
   input wire logic s_arvalid_i,
   output logic s_arready_o,
   output logic [pssb_pkg::PSSB_DATA_W-1:0] s_rdata_o,
   output logic [1:0] s_rresp_o,
   output logic s_rvalid_o,
   input wire logic s_rready_i,
   // Register file side
   output logic wr_en_o,
   output logic [1:0] wr_sel_o,
   output logic [pssb_pkg::PSSB_REG_W-1:0] wr_data_o,
   output logic [1:0] wr_strb_o,
   input wire logic [pssb_pkg::PSSB_REG_W-1:0] rd_data_i
);
   import pssb_pkg::*;

   logic aw_held;
   logic w_held;
   logic [PSSB_ADDR_W-1:0] aw_addr;
   logic [PSSB_REG_W-1:0] w_data;
   logic [1:0] w_strb;
   logic next_aw_held;
   logic next_w_held;
   logic next_bvalid;
   logic next_rvalid;
   wire aw_take = s_awvalid_i & s_awready_o;
   wire w_take = s_wvalid_i & s_wready_o;
   wire ar_take = s_arvalid_i & s_arready_o;
   wire do_write = aw_held & w_held & ~s_bvalid_o;
   wire [1:0] aw_sel = pssb_reg_sel(aw_addr);
   wire [1:0] ar_sel = pssb_reg_sel(s_araddr_i);

   // Slot and response state after this edge
   assign next_aw_held = aw_take | (aw_held & ~do_write);
   assign next_w_held = w_take | (w_held & ~do_write);
   assign next_bvalid = do_write | (s_bvalid_o & ~s_bready_i);
   assign next_rvalid = ar_take | (s_rvalid_o & ~s_rready_i);

   // Ready while the slot is free and no response is pending, registered
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_awready_o <= 1'b1;
         s_wready_o <= 1'b1;
         s_arready_o <= 1'b1;
      end else begin
         s_awready_o <= ~next_aw_held & ~next_bvalid;
         s_wready_o <= ~next_w_held & ~next_bvalid;
         s_arready_o <= ~next_rvalid;
      end
   end

   // Capture address and data in either order
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
      end else begin
         if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= s_awaddr_i;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_wdata_i[PSSB_REG_W-1:0];
            w_strb <= s_wstrb_i[1:0];
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // Write strobe to the register file and response
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_en_o <= 1'b0;
         wr_sel_o <= PSSB_SEL_NONE;
         wr_data_o <= '0;
         wr_strb_o <= '0;
         s_bvalid_o <= 1'b0;
         s_bresp_o <= PSSB_RESP_OKAY;
      end else begin
         wr_en_o <= do_write & (aw_sel != PSSB_SEL_NONE);
         wr_sel_o <= aw_sel;
         wr_data_o <= w_data;
         wr_strb_o <= w_strb;
         if (do_write) begin
            s_bvalid_o <= 1'b1;
            s_bresp_o <= (aw_sel == PSSB_SEL_NONE) ? PSSB_RESP_SLVERR : PSSB_RESP_OKAY;
         end else if (s_bready_i) begin
            s_bvalid_o <= 1'b0;
         end
      end
   end

   // Read answer one cycle after the address is taken
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_rvalid_o <= 1'b0;
         s_rdata_o <= '0;
         s_rresp_o <= PSSB_RESP_OKAY;
      end else if (ar_take) begin
         s_rvalid_o <= 1'b1;
         s_rdata_o <= {16'h0000, rd_data_i};
         s_rresp_o <= (ar_sel == PSSB_SEL_NONE) ? PSSB_RESP_SLVERR : PSSB_RESP_OKAY;
      end else if (s_rready_i) begin
         s_rvalid_o <= 1'b0;
      end
   end

endmodule : pssb_axil
`default_nettype wire

//--- verilog/pssb_top.sv
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module pssb_top (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   // AXI4-Lite write address
   input wire logic [pssb_pkg::PSSB_ADDR_W-1:0] s_awaddr_i,
   input wire logic s_awvalid_i,
   output logic s_awready_o,
   // AXI4-Lite write data
   input wire logic [pssb_pkg::PSSB_DATA_W-1:0] s_wdata_i,
   input wire logic [3:0] s_wstrb_i,
   input wire logic s_wvalid_i,
   output logic s_wready_o,
   // AXI4-Lite write response
   output logic [1:0] s_bresp_o,
   output logic s_bvalid_o,
   input wire logic s_bready_i,
   // AXI4-Lite read address
   input wire logic [pssb_pkg::PSSB_ADDR_W-1:0] s_araddr_i,
   input wire logic s_arvalid_i,
   output logic s_arready_o,
   // AXI4-Lite read data
   output logic [pssb_pkg::PSSB_DATA_W-1:0] s_rdata_o,
   output logic [1:0] s_rresp_o,
   output logic s_rvalid_o,
   input wire logic s_rready_i,
   // Link status from negotiation and PCS
   input wire pssb_pkg::pssb_link_t link_i,
   // MII transmit side
   input wire logic tx_en_i,
   input wire logic tx_er_i,
   output logic tx_en_o,
   output logic tx_er_o,
   // Receive idle symbol errors
   input wire logic rx_idle_i,
   input wire logic rx_sym_err_i,
   output logic idle_rx_err_o,
   // Configuration in effect and derived controls
   output pssb_pkg::pssb_cfg_t cfg_o,
   output logic strap_latch_pulse_o,
   output logic full_duplex_o,
   output logic link_led_o,
   output logic mii_isolate_o,
   output logic rmii_rx_on_rx_clk_o
);
   import pssb_pkg::*;

   // Register file signals
   logic wr_en;
   logic [1:0] wr_sel;
   logic [PSSB_REG_W-1:0] wr_data;
   logic [1:0] wr_strb;
   logic [PSSB_REG_W-1:0] rd_data;
   logic [PSSB_REG_W-1:0] strap_control_one;
   logic [PSSB_REG_W-1:0] strap_control_two;
   logic [PSSB_REG_W-1:0] next_one;
   logic [PSSB_REG_W-1:0] next_two;
   logic [PSSB_REG_W-1:0] strb_mask;
   logic force_fast_pd;
   logic [PSSB_REG_W-1:0] two_view;
   logic latch_req;

   // Configuration and datapath state
   pssb_cfg_t next_cfg;
   logic fd_now;
   logic next_full_duplex;
   logic next_link_led;
   logic next_isolate;
   logic tx_en_d;
   logic nibble_odd;
   logic odd_ext;
   logic next_tx_en;
   logic next_tx_er;
   logic next_idle_err;

   // Bus slave
   pssb_axil u_axil (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .s_awaddr_i(s_awaddr_i),
      .s_awvalid_i(s_awvalid_i),
      .s_awready_o(s_awready_o),
      .s_wdata_i(s_wdata_i),
      .s_wstrb_i(s_wstrb_i),
      .s_wvalid_i(s_wvalid_i),
      .s_wready_o(s_wready_o),
      .s_bresp_o(s_bresp_o),
      .s_bvalid_o(s_bvalid_o),
      .s_bready_i(s_bready_i),
      .s_araddr_i(s_araddr_i),
      .s_arvalid_i(s_arvalid_i),
      .s_arready_o(s_arready_o),
      .s_rdata_o(s_rdata_o),
      .s_rresp_o(s_rresp_o),
      .s_rvalid_o(s_rvalid_o),
      .s_rready_i(s_rready_i),
      .wr_en_o(wr_en),
      .wr_sel_o(wr_sel),
      .wr_data_o(wr_data),
      .wr_strb_o(wr_strb),
      .rd_data_i(rd_data)
   );

   // Byte-lane mask from the write strobes
   assign strb_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

   // Crossover modes in register one force fast link-up
   assign force_fast_pd = strap_control_one[PSSB_ONE_FAST_MDIX]
                        | strap_control_one[PSSB_ONE_ROBUST_MDIX];

   // Register two as software sees it
   assign two_view = (strap_control_two & PSSB_TWO_WMASK)
                   | (16'(force_fast_pd) << PSSB_TWO_FAST_PD);

   // Next register values under byte strobes
   assign next_one = (strap_control_one & ~(strb_mask & PSSB_ONE_WMASK))
                   | (wr_data & strb_mask & PSSB_ONE_WMASK);
   assign next_two = (strap_control_two & ~(strb_mask & PSSB_TWO_WMASK))
                   | (wr_data & strb_mask & PSSB_TWO_WMASK);

   // Config-done written as one in an enabled lane
   assign latch_req = wr_en & (wr_sel == PSSB_SEL_ONE) & wr_strb[1]
                    & wr_data[PSSB_ONE_CFG_DONE];

   // Read mux
   assign rd_data = (pssb_reg_sel(s_araddr_i) == PSSB_SEL_ONE) ? strap_control_one :
                    (pssb_reg_sel(s_araddr_i) == PSSB_SEL_TWO) ? two_view :
                    16'h0000;

   // Software-visible registers
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         strap_control_one <= PSSB_ONE_RST;
         strap_control_two <= PSSB_TWO_RST;
      end else if (wr_en) begin
         if (wr_sel == PSSB_SEL_ONE) begin
            strap_control_one <= next_one;
         end
         if (wr_sel == PSSB_SEL_TWO) begin
            strap_control_two <= next_two;
         end
      end
   end

   // Field values to latch, from the register as read back
   assign next_cfg.fast_pd_linkup = two_view[PSSB_TWO_FAST_PD];
   assign next_cfg.forced_full_duplex_ext = two_view[PSSB_TWO_FD_EXT];
   assign next_cfg.link_indicator_fd_only = two_view[PSSB_TWO_LED_FD];
   assign next_cfg.isolate_on_half_duplex = two_view[PSSB_TWO_ISOLATE];
   assign next_cfg.idle_symbol_error_detect = two_view[PSSB_TWO_IDLE_ERR];
   assign next_cfg.odd_nibble_disable = two_view[PSSB_TWO_ODD_DIS];
   assign next_cfg.rmii_rx_on_rx_clk = two_view[PSSB_TWO_RMII_CLK];

   // Internal reset pulse and strap latch
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         strap_latch_pulse_o <= 1'b0;
         cfg_o <= pssb_cfg_t'(PSSB_TWO_RST[6:0]);
      end else begin
         strap_latch_pulse_o <= latch_req;
         if (strap_latch_pulse_o) begin
            cfg_o <= next_cfg;
         end
      end
   end

   // Duplex decision with the extended ability
   assign fd_now = (cfg_o.forced_full_duplex_ext & link_i.partner_forced_100
                    & link_i.local_an_or_forced_100) ? 1'b1
                 : link_i.std_full_duplex;

   // Link indicator, isolation and duplex outputs
   assign next_full_duplex = link_i.link_up & fd_now;
   assign next_link_led = cfg_o.link_indicator_fd_only
                        ? (link_i.link_up & link_i.speed_100 & fd_now)
                        : link_i.link_up;
   assign next_isolate = cfg_o.isolate_on_half_duplex & link_i.link_up
                       & link_i.speed_100 & ~fd_now;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         full_duplex_o <= 1'b0;
         link_led_o <= 1'b0;
         mii_isolate_o <= 1'b0;
         rmii_rx_on_rx_clk_o <= 1'b0;
      end else begin
         full_duplex_o <= next_full_duplex;
         link_led_o <= next_link_led;
         mii_isolate_o <= next_isolate;
         rmii_rx_on_rx_clk_o <= cfg_o.rmii_rx_on_rx_clk;
      end
   end

   // Odd-nibble end of transmit enable
   assign odd_ext = tx_en_d & ~tx_en_i & nibble_odd & ~cfg_o.odd_nibble_disable;
   assign next_tx_en = tx_en_i | odd_ext;
   assign next_tx_er = (tx_en_i & tx_er_i) | odd_ext;

   // Nibble parity and transmit outputs
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_en_d <= 1'b0;
         nibble_odd <= 1'b0;
         tx_en_o <= 1'b0;
         tx_er_o <= 1'b0;
      end else begin
         tx_en_d <= tx_en_i;
         nibble_odd <= tx_en_i ? ~nibble_odd : 1'b0;
         tx_en_o <= next_tx_en;
         tx_er_o <= next_tx_er;
      end
   end

   // Receive symbol error during idle
   assign next_idle_err = cfg_o.idle_symbol_error_detect & rx_idle_i & rx_sym_err_i;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         idle_rx_err_o <= 1'b0;
      end else begin
         idle_rx_err_o <= next_idle_err;
      end
   end

endmodule : pssb_top
`default_nettype wire

//--- tb/pssb_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module pssb_top_asserts
   import pssb_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   // Datapath inputs
   input wire pssb_pkg::pssb_link_t link_i,
   input wire logic tx_en_i,
   input wire logic rx_idle_i,
   input wire logic rx_sym_err_i,
   // Observed outputs
   input wire logic tx_en_o,
   input wire logic tx_er_o,
   input wire logic idle_rx_err_o,
   input wire pssb_pkg::pssb_cfg_t cfg_o,
   input wire logic strap_latch_pulse_o,
   input wire logic full_duplex_o,
   input wire logic link_led_o,
   input wire logic mii_isolate_o,
   input wire logic rmii_rx_on_rx_clk_o
);
   logic ok;
   logic par;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   // History valid flag and transmit nibble parity
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ok <= 1'b0;
         par <= 1'b0;
      end else begin
         ok <= 1'b1;
         par <= tx_en_i ? ~par : 1'b0;
      end
   end
   a_pulse_single: assert property (strap_latch_pulse_o |=> !strap_latch_pulse_o)
      else $error("latch pulse longer than one cycle");
   a_cfg_hold: assert property (ok && !$past(strap_latch_pulse_o) |-> $stable(cfg_o))
      else $error("config changed without latch pulse");
   a_fd_forced: assert property (ok && $past(cfg_o.forced_full_duplex_ext
      && link_i.partner_forced_100 && link_i.local_an_or_forced_100)
      |-> full_duplex_o == $past(link_i.link_up))
      else $error("forced full duplex not applied");
   a_fd_std: assert property (ok && !$past(cfg_o.forced_full_duplex_ext)
      |-> full_duplex_o == $past(link_i.link_up && link_i.std_full_duplex))
      else $error("standard duplex decision wrong");
   a_led_fd_only: assert property (ok && $past(cfg_o.link_indicator_fd_only)
      |-> link_led_o == ($past(link_i.speed_100) && full_duplex_o))
      else $error("indicator lit outside full duplex link");
   a_led_any: assert property (ok && !$past(cfg_o.link_indicator_fd_only)
      |-> link_led_o == $past(link_i.link_up))
      else $error("indicator does not follow link");
   a_iso_half: assert property (ok |-> mii_isolate_o == ($past(cfg_o.isolate_on_half_duplex
      && link_i.link_up && link_i.speed_100) && !full_duplex_o))
      else $error("isolation output wrong");
   a_idle_err: assert property (ok |-> idle_rx_err_o == $past(cfg_o.idle_symbol_error_detect
      && rx_idle_i && rx_sym_err_i))
      else $error("idle symbol error detect wrong");
   a_odd_extend: assert property ($fell(tx_en_i) && par && !cfg_o.odd_nibble_disable
      |=> tx_en_o && tx_er_o)
      else $error("odd nibble end not extended");
   a_odd_off: assert property ($fell(tx_en_i) && cfg_o.odd_nibble_disable
      |=> !tx_en_o && !tx_er_o)
      else $error("odd nibble error with detection off");
   a_rmii_sel: assert property (ok |-> rmii_rx_on_rx_clk_o == $past(cfg_o.rmii_rx_on_rx_clk))
      else $error("receive clock select wrong");
endmodule : pssb_top_asserts
bind pssb_top pssb_top_asserts i_chk (.ref_clk_i, .arst_n_i, .link_i, .tx_en_i, .rx_idle_i,
   .rx_sym_err_i, .tx_en_o, .tx_er_o, .idle_rx_err_o, .cfg_o, .strap_latch_pulse_o,
   .full_duplex_o, .link_led_o, .mii_isolate_o, .rmii_rx_on_rx_clk_o);
`default_nettype wire

//--- tb/pssb_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pssb_top_tb;
   import pssb_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] awaddr = 8'h0;
   logic [7:0] araddr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   pssb_link_t link = 5'h0;
   logic tx_en = 1'b0, tx_er = 1'b0, rx_idle = 1'b0, rx_err = 1'b0;
   logic tx_en_q, tx_er_q, idle_err, pulse, fd, led, iso, rmii;
   pssb_cfg_t cfg;
   int failures = 0;
   int total_checks = 0;
   int pulses = 0;
   logic [31:0] seed = 32'h98DB;

   pssb_top i_dut (.ref_clk_i(clk), .arst_n_i(arst_n), .s_awaddr_i(awaddr),
      .s_awvalid_i(awvalid), .s_awready_o(awready), .s_wdata_i(wdata), .s_wstrb_i(wstrb),
      .s_wvalid_i(wvalid), .s_wready_o(wready), .s_bresp_o(bresp), .s_bvalid_o(bvalid),
      .s_bready_i(bready), .s_araddr_i(araddr), .s_arvalid_i(arvalid),
      .s_arready_o(arready), .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid),
      .s_rready_i(rready), .link_i(link), .tx_en_i(tx_en), .tx_er_i(tx_er),
      .tx_en_o(tx_en_q), .tx_er_o(tx_er_q), .rx_idle_i(rx_idle), .rx_sym_err_i(rx_err),
      .idle_rx_err_o(idle_err), .cfg_o(cfg), .strap_latch_pulse_o(pulse),
      .full_duplex_o(fd), .link_led_o(led), .mii_isolate_o(iso), .rmii_rx_on_rx_clk_o(rmii));

   // Clock and latch pulse counter
   always #50 clk = ~clk;
   always @(negedge clk) if (pulse === 1'b1) pulses++;

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Write: both channels offered, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw, w, b;
      int n;
      b = 0;
      n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b && n < 50) begin
         @(negedge clk);
         aw = awvalid && awready;
         w = wvalid && wready;
         b = bvalid;
         r = bresp;
         n++;
         @(posedge clk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      if (!b) failures++;
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      bit ar, v;
      int n;
      v = 0;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!v && n < 50) begin
         @(negedge clk);
         ar = arvalid && arready;
         v = rvalid;
         d = rdata;
         r = rresp;
         n++;
         @(posedge clk);
         if (ar) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      if (!v) failures++;
      @(posedge clk);
   endtask : rd

   // Expected duplex, indicator, isolation and idle error for one input word
   function automatic logic [3:0] dp_exp(input logic [31:0] p, input logic [6:0] c);
      logic fdx;
      fdx = (c[5] & p[2] & p[1]) | p[0];
      return {p[4] & fdx, c[4] ? (p[4] & p[3] & fdx) : p[4], c[3] & p[4] & p[3] & ~fdx,
         c[2] & p[8] & p[9]};
   endfunction : dp_exp

   // Random link, transmit and receive activity; outputs checked one cycle on
   task automatic traffic(input int n, input logic [6:0] c);
      logic [31:0] r, p, g, e;
      logic odd, en_d, ext;
      odd = 1'b0;
      en_d = 1'b0;
      p = {22'h0, rx_err, rx_idle, tx_er, 1'b0, tx_en, link};
      repeat (n) begin
         @(posedge clk);
         r = xs();
         link <= r[4:0];
         tx_en <= r[5] | r[6];
         tx_er <= r[7];
         rx_idle <= r[8];
         rx_err <= r[9];
         @(negedge clk);
         ext = en_d & ~p[5] & odd & ~c[1];
         e = {25'h0, c[0], p[5] | ext, (p[5] & p[7]) | ext, dp_exp(p, c)};
         g = {25'h0, rmii, tx_en_q, tx_er_q, fd, led, iso, idle_err};
         chk(g, e);
         odd = p[5] ? ~odd : 1'b0;
         en_d = p[5];
         p = r | {26'h0, r[6], 5'h0};
      end
      @(posedge clk);
      tx_en <= 1'b0;
   endtask : traffic

   task automatic conclude();
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   // Hang guard
   initial begin
      #(100 * 20000);
      failures++;
      conclude();
   end

   initial begin
      logic [31:0] r, v, one, e2;
      logic [1:0] rs;
      logic [6:0] ecfg;
      int nl;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      chk(32'(cfg), 32'h4);
      rd(PSSB_ADDR_CTRL_TWO, r, rs);
      chk(r, 32'h4);
      rd(8'h2C, r, rs);
      chk(r, 32'h0);
      chk(32'(rs), 32'(PSSB_RESP_SLVERR));
      wr(8'h2C, 32'hFFFF, rs);
      chk(32'(rs), 32'(PSSB_RESP_SLVERR));
      $display("test reset finished");
      wr(PSSB_ADDR_CTRL_TWO, 32'hFFFF, rs);
      chk(32'(rs), 32'(PSSB_RESP_OKAY));
      rd(PSSB_ADDR_CTRL_TWO, r, rs);
      chk(r, 32'h3FFF);
      chk(32'(cfg), 32'h4);
      wr(PSSB_ADDR_CTRL_ONE, 32'h8000, rs);
      repeat (2) @(posedge clk);
      chk(32'(cfg), 32'h7F);
      wstrb <= 4'h2;
      wr(PSSB_ADDR_CTRL_TWO, 32'hC000, rs);
      wstrb <= 4'h1;
      wr(PSSB_ADDR_CTRL_ONE, 32'h8060, rs);
      wstrb <= 4'hF;
      rd(PSSB_ADDR_CTRL_TWO, r, rs);
      chk(r, 32'h00FF);
      rd(PSSB_ADDR_CTRL_ONE, r, rs);
      chk(r, 32'h8060);
      chk(32'(pulses), 32'h1);
      chk(32'(cfg), 32'h7F);
      $display("test latch finished");
      ecfg = 7'h7F;
      nl = 1;
      for (int i = 0; i < 12; i++) begin
         v = xs();
         one = xs() & 32'h8060;
         wr(PSSB_ADDR_CTRL_TWO, v, rs);
         chk(32'(cfg), 32'(ecfg));
         wr(PSSB_ADDR_CTRL_ONE, one, rs);
         e2 = (v & 32'h3FFF) | ((one[6] | one[5]) ? 32'h40 : 32'h0);
         rd(PSSB_ADDR_CTRL_TWO, r, rs);
         chk(r, e2);
         rd(PSSB_ADDR_CTRL_ONE, r, rs);
         chk(r, one);
         if (one[15]) begin
            ecfg = e2[6:0];
            nl++;
         end
         chk(32'(cfg), 32'(ecfg));
         traffic(40, ecfg);
      end
      chk(32'(pulses), 32'(nl));
      $display("test random finished");
      conclude();
   end
endmodule : pssb_top_tb
`default_nettype wire
